// ---- rtl/oprd_host.sv ----
module oprd_host
  import oprd_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned CNT_W_P = CNT_W
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // User commands
  input wire logic i_program,
  input wire oprd_pkg::oprd_mode_e i_mode,
  input wire logic i_measure,
  input wire logic [CNT_W_P-1:0] i_abort_after,
  output logic o_ready,
  // User results
  output logic o_done,
  output logic o_aborted,
  output logic o_in_range,
  output logic [CNT_W_P-1:0] o_width_raw,
  output logic [CNT_W_P-1:0] o_width_corr,
  // Sensor pins
  output logic o_shutdown_latch_in,
  output logic o_mode_select_in,
  output logic o_measure_strobe_in,
  input wire logic i_pulse_result_out
);
  import oprd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [6:0] {
    ST_SHUT = 7'h01,
    ST_SETUP = 7'h02,
    ST_LATCH = 7'h04,
    ST_POWERUP = 7'h08,
    ST_IDLE = 7'h10,
    ST_WAIT_LOW = 7'h20,
    ST_PULSE = 7'h40
  } oprd_state_e;

  oprd_state_e st_r, st_nxt;
  oprd_mode_e mode_r, mode_nxt;
  logic [CNT_W_P-1:0] tmr_r, tmr_nxt;
  logic [CNT_W_P-1:0] abort_r, abort_nxt;
  logic sd_r, sd_nxt, md_r, md_nxt, stx_r, stx_nxt;
  logic done_r, done_nxt, abt_r, abt_nxt, rng_r, rng_nxt;
  logic [CNT_W_P-1:0] wr_r, wr_nxt, wc_r, wc_nxt;
  logic prx_s1_r, prx_s2_r, prx_d_r;
  logic prx_fall, prx_rise, t_start, t_run, limit_hit;
  logic [CNT_W_P-1:0] ofs;
  logic [CNT_W_P-1:0] t_raw, t_corr;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prx_s1_r <= 1'b1;
      prx_s2_r <= 1'b1;
      prx_d_r <= 1'b1;
    end else begin
      prx_s1_r <= i_pulse_result_out;
      prx_s2_r <= prx_s1_r;
      prx_d_r <= prx_s2_r;
    end
  end

  assign prx_fall = !sd_r && prx_d_r && !prx_s2_r;
  assign prx_rise = !sd_r && !prx_d_r && prx_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // offset by measured diode
  always_comb begin
    case (mode_r)
      OPRD_VISIBLE_AMBIENT: ofs = CNT_W_P'(VIS_OFS_CYC);
      OPRD_VIS_IR_HIGH: ofs = CNT_W_P'(IRH_OFS_CYC);
      OPRD_VIS_IR_LOW: ofs = CNT_W_P'(IRL_OFS_CYC);
      default: ofs = '0;
    endcase
  end

  assign t_start = (st_r == ST_WAIT_LOW) && prx_fall;
  assign t_run = (st_r == ST_PULSE);
  assign limit_hit = (abort_r != '0) && (t_raw >= abort_r);

  oprd_pulse_timer #(
    .CNT_W(CNT_W_P)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(t_start),
    .i_run(t_run),
    .i_offset(ofs),
    .o_raw(t_raw),
    .o_corrected(t_corr)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    tmr_nxt = tmr_r;
    abort_nxt = abort_r;
    sd_nxt = sd_r;
    md_nxt = md_r;
    stx_nxt = stx_r;
    done_nxt = 1'b0;
    abt_nxt = abt_r;
    rng_nxt = rng_r;
    wr_nxt = wr_r;
    wc_nxt = wc_r;
    case (st_r)
      ST_SHUT: begin
        sd_nxt = 1'b1;
        stx_nxt = 1'b0;
        if (i_program) begin
          mode_nxt = i_mode;
          md_nxt = i_mode[MODE_MDL_BIT];
          stx_nxt = i_mode[MODE_STX_BIT];
          tmr_nxt = CNT_W_P'(SETUP_CYC);
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_r <= CNT_W_P'(1)) begin
          sd_nxt = 1'b0;
          tmr_nxt = CNT_W_P'(SETUP_CYC);
          st_nxt = ST_LATCH;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      ST_LATCH: begin
        if (tmr_r <= CNT_W_P'(1)) begin
          md_nxt = mode_r[MODE_MDS_BIT];
          stx_nxt = 1'b0;
          tmr_nxt = CNT_W_P'(POWERUP_CYCLES);
          st_nxt = ST_POWERUP;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      ST_POWERUP: begin
        // Strobe stays low through the power-up latency
        if (tmr_r <= CNT_W_P'(1)) begin
          st_nxt = ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      ST_IDLE: begin
        if (i_program) begin
          sd_nxt = 1'b1;
          st_nxt = ST_SHUT;
        end else if (i_measure) begin
          stx_nxt = 1'b1;
          abort_nxt = i_abort_after;
          abt_nxt = 1'b0;
          rng_nxt = 1'b0;
          st_nxt = ST_WAIT_LOW;
        end
      end
      ST_WAIT_LOW: begin
        if (prx_fall) begin
          st_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (prx_rise) begin
          stx_nxt = 1'b0;
          done_nxt = 1'b1;
          wr_nxt = t_raw;
          wc_nxt = t_corr;
          st_nxt = ST_IDLE;
        end else if (limit_hit) begin
          stx_nxt = 1'b0;
          abt_nxt = 1'b1;
          rng_nxt = !prx_s2_r;
          done_nxt = 1'b1;
          wr_nxt = t_raw;
          wc_nxt = t_corr;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_SHUT;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r <= ST_SHUT;
      mode_r <= OPRD_PROX_HIGH_CURRENT;
      tmr_r <= '0;
      abort_r <= '0;
      sd_r <= 1'b1;
      md_r <= 1'b0;
      stx_r <= 1'b0;
      done_r <= 1'b0;
      abt_r <= 1'b0;
      rng_r <= 1'b0;
      wr_r <= '0;
      wc_r <= '0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      tmr_r <= tmr_nxt;
      abort_r <= abort_nxt;
      sd_r <= sd_nxt;
      md_r <= md_nxt;
      stx_r <= stx_nxt;
      done_r <= done_nxt;
      abt_r <= abt_nxt;
      rng_r <= rng_nxt;
      wr_r <= wr_nxt;
      wc_r <= wc_nxt;
    end
  end

  assign o_ready = (st_r == ST_IDLE);
  assign o_done = done_r;
  assign o_aborted = abt_r;
  assign o_in_range = rng_r;
  assign o_width_raw = wr_r;
  assign o_width_corr = wc_r;
  assign o_shutdown_latch_in = sd_r;
  assign o_mode_select_in = md_r;
  assign o_measure_strobe_in = stx_r;

  ////////////////////////////////////////////////////////////////////////
  sequence s_limit_abort;
    (st_r == ST_PULSE) && !prx_rise && limit_hit;
  endsequence

  chk_abort_drops_strobe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_limit_abort |=> !o_measure_strobe_in && o_aborted && o_done)
    else $error("abort did not drop strobe");

  chk_sample_at_fall: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_limit_abort |=> o_in_range == !$past(prx_s2_r))
    else $error("in-range not sampled at strobe fall");

  chk_latch_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_shutdown_latch_in) |-> $stable(o_mode_select_in) && $stable(o_measure_strobe_in))
    else $error("mode pins moved at latch edge");

  chk_strobe_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_measure_strobe_in) |->
      (o_shutdown_latch_in ? (st_r == ST_SETUP) : (st_r == ST_WAIT_LOW)))
    else $error("strobe rose outside measurement start");

  chk_shut_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_shutdown_latch_in |-> !prx_fall && !prx_rise && !o_ready && !o_done &&
      (st_r inside {ST_SHUT, ST_SETUP}))
    else $error("result read in shutdown");

  chk_rise_completes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r == ST_PULSE) && prx_rise |=> o_done && !o_aborted && o_width_raw == $past(t_raw))
    else $error("width not captured at pulse end");

endmodule

// ---- rtl/oprd_pkg.sv ----
package oprd_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POWERUP_US = 535;
  localparam int unsigned POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_NS = 100;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Zero-lux offsets, in nanoseconds, and their cycle counts (rounded down)
  localparam int unsigned VIS_OFS_NS = 7100;
  localparam int unsigned IRH_OFS_NS = 11300;
  localparam int unsigned IRL_OFS_NS = 9900;
  localparam int unsigned VIS_OFS_CYC = VIS_OFS_NS / CLK_PERIOD_NS;
  localparam int unsigned IRH_OFS_CYC = IRH_OFS_NS / CLK_PERIOD_NS;
  localparam int unsigned IRL_OFS_CYC = IRL_OFS_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 24;

  // Mode code: {strobe latch, mode latch, mode static}
  typedef enum logic [2:0] {
    OPRD_PROX_HIGH_CURRENT = 3'h0,
    OPRD_OFFSET_CAL = 3'h1,
    OPRD_PROX_LOW_CURRENT = 3'h2,
    OPRD_PROX_LOW_HIGH_REFLECT = 3'h3,
    OPRD_VIS_IR_LOW = 3'h4,
    OPRD_VISIBLE_AMBIENT = 3'h5,
    OPRD_VIS_IR_HIGH = 3'h6,
    OPRD_RESERVED = 3'h7
  } oprd_mode_e;

  localparam int unsigned MODE_STX_BIT = 2;
  localparam int unsigned MODE_MDL_BIT = 1;
  localparam int unsigned MODE_MDS_BIT = 0;

endpackage

// ---- rtl/oprd_pulse_timer.sv ----
// Times the low phase of the result pulse and removes an offset.
module oprd_pulse_timer #(
  parameter int unsigned CNT_W = 24
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic i_run,
  input wire logic [CNT_W-1:0] i_offset,
  // Result
  output logic [CNT_W-1:0] o_raw,
  output logic [CNT_W-1:0] o_corrected
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_start) begin
      cnt_nxt = '0;
    end else if (i_run && cnt_r != '1) begin
      // Saturate rather than wrap on a stuck-low pulse
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_raw = cnt_r;
  assign o_corrected = (cnt_r > i_offset) ? cnt_r - i_offset : '0;

endmodule

// ---- sim/oprd_sensor_model.sv ----
// Behavioural sensor: clockless, result pin pulled up at the host
module oprd_sensor_model (
  // Host side pins
  input wire logic i_shutdown_latch_in,
  input wire logic i_mode_select_in,
  input wire logic i_measure_strobe_in,
  // Bench control: low time in 10 ns units
  input wire logic [31:0] i_width_cyc,
  // Outputs
  output logic o_pulse_result_out,
  output logic o_led_current_sink
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stx_l = 1'b0;
  logic md_l = 1'b0;
  logic low_r = 1'b0;
  always @(negedge i_shutdown_latch_in) begin
    stx_l = i_measure_strobe_in;
    md_l = i_mode_select_in;
  end
  // one pulse per strobe rise outside shutdown, length from light
  always @(posedge i_measure_strobe_in) begin : cyc
    if (!i_shutdown_latch_in) begin
      #15;
      low_r = 1'b1;
      #(i_width_cyc * 10);
      low_r = 1'b0;
    end
  end
  always @(negedge i_measure_strobe_in) begin
    disable cyc;
    low_r = 1'b0;
  end
  // released in shutdown, so the pull-up wins
  assign o_pulse_result_out = !(low_r && !i_shutdown_latch_in);
  // LED only while low, never in ambient or calibration
  assign o_led_current_sink = low_r && !stx_l && !(!md_l && i_mode_select_in);
endmodule

// ---- sim/oprd_host_tb.sv ----
module oprd_host_tb;
  import oprd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int raw; int corr; bit ab; bit led;} oprd_exp_s;
  logic clk = 0, rst_n = 0, prog = 0, meas = 0, ready, done, abrt, in_rng, sd, md, measure_strobe_in;
  logic res, led, led_seen;
  oprd_mode_e mode = OPRD_PROX_HIGH_CURRENT;
  logic [CNT_W-1:0] ab_after = '0, raw, corr;
  logic [31:0] width = 32'h64;
  oprd_exp_s exp_q[$];
  int n_mismatch = 0, n_compared = 0, n_done = 0, cyc = 0, seed = 3335;
  oprd_host #(.POWERUP_CYCLES(20)) u_oprd_host (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_program(prog), .i_mode(mode), .i_measure(meas), .i_abort_after(ab_after),
    .o_ready(ready), .o_done(done), .o_aborted(abrt), .o_in_range(in_rng),
    .o_width_raw(raw), .o_width_corr(corr), .o_shutdown_latch_in(sd),
    .o_mode_select_in(md), .o_measure_strobe_in(measure_strobe_in), .i_pulse_result_out(res));
  oprd_sensor_model u_oprd_sensor_model (.i_shutdown_latch_in(sd), .i_mode_select_in(md),
    .i_measure_strobe_in(measure_strobe_in), .i_width_cyc(width), .o_pulse_result_out(res),
    .o_led_current_sink(led));
  always #5 clk = ~clk;
  always @(posedge led) led_seen = 1'b1;
  //////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
    n_compared++;
    // Tolerance covers the synchroniser phase
    if (!(seen === exp || (tol != 0 && ((seen - exp + 32'h2) < 32'h5) === 1'b1))) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic program_mode(input oprd_mode_e m);
    int t;
    t = 0;
    @(negedge clk);
    mode = m;
    prog = 1;
    // Held until the latch edge so an idle host passes through shutdown
    do begin @(negedge clk); t++; end while (sd !== 1'b0 && t < 100);
    prog = 0;
    check(md, m[MODE_MDL_BIT], 0);
    check(measure_strobe_in, m[MODE_STX_BIT], 0);
    while (ready !== 1'b1 && t < 200) begin @(negedge clk); t++; end
    check(md, m[MODE_MDS_BIT], 0);
    check(measure_strobe_in, 0, 0);
  endtask
  task automatic measure(input int w, input int ab);
    oprd_exp_s e;
    int ofs, k, t;
    ofs = mode == OPRD_VISIBLE_AMBIENT ? VIS_OFS_CYC : mode == OPRD_VIS_IR_HIGH ? IRH_OFS_CYC :
      mode == OPRD_VIS_IR_LOW ? IRL_OFS_CYC : 0;
    e.ab = ab != 0 && ab < w;
    e.raw = e.ab ? ab : w;
    e.corr = e.raw > ofs ? e.raw - ofs : 0;
    e.led = mode inside {OPRD_PROX_HIGH_CURRENT, OPRD_PROX_LOW_CURRENT, OPRD_PROX_LOW_HIGH_REFLECT};
    exp_q.push_back(e);
    width = 32'(w);
    led_seen = 1'b0;
    k = n_done;
    t = 0;
    ab_after = CNT_W'(ab);
    meas = 1;
    @(negedge clk);
    meas = 0;
    while (n_done == k && t < 5000) begin @(negedge clk); t++; end
    check(32'(n_done - k), 1, 0);
  endtask
  //////////////////////////////////////////////////////////////////
  // Each result is matched against the oldest note
  always @(negedge clk) begin
    if (done === 1'b1) begin
      oprd_exp_s e;
      check(32'(exp_q.size() != 0), 1, 0);
      e = exp_q.pop_front();
      check(32'(raw), e.raw, 2);
      check(32'(corr), e.corr, 2);
      check(abrt, e.ab, 0);
      check(in_rng, e.ab, 0);
      check(led_seen, e.led, 0);
      check(led, 0, 0);
      n_done++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    check(sd, 1, 0);
    check(ready, 0, 0);
    rst_n = 1;
    // every usable mode, random light levels
    for (int i = 0; i < 7; i++) begin
      program_mode(oprd_mode_e'(i));
      repeat (2) measure(300 + int'($unsigned($random(seed)) % 1200), 0);
      $display("mode %0d test done", i);
    end
    // abort, then a cycle that ends before the limit
    program_mode(OPRD_PROX_LOW_CURRENT);
    measure(800, 200);
    measure(150, 400);
    $display("abort test done");
    end_sim;
  end
endmodule
